// ### design/pcl_phy_config.sv
// Negotiation control, crossover, strap capture, isolation and indicators.
`timescale 1ns/10ps
`default_nettype none
module pcl_phy_config #(
  parameter int unsigned BREAK_CYC = pcl_pkg::BREAK_LINK_CYC,
  parameter int unsigned NEG_CYC = pcl_pkg::NEG_LIMIT_CYC,
  parameter int unsigned LOSS_CYC = pcl_pkg::LINK_LOSS_CYC,
  parameter int unsigned BLINK_PERIOD = pcl_pkg::BLINK_CYC
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic mdcPin,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe_n,
  input wire pcl_pkg::pcl_strap_t strapPins,
  input wire pcl_pkg::pcl_line_t lineStat,
  output pcl_pkg::pcl_ctl_t ctl,
  output logic miiOe_n,
  output logic linkIndicatorOut,
  output logic speedIndicatorOut,
  output logic activityCollisionIndicator
);
  import pcl_pkg::*;

  pcl_strap_t strapS1_r, strapS2_r, strap_r;
  logic [1:0] settle_r;
  logic strapDone_r, strapLoad;
  logic speed_r, anEn_r, isolate_r, restart_r, duplex_r, anArmed_r;
  logic xoverAuto_r, xoverForce_r, strapIsolate_r, xoverSel_r;
  logic [1:0] indicatorModeField_r;
  logic [4:0] stationAddr_r;
  logic wrStrobe, wrBasic, wrPhy, negEnable, linkGood;
  logic [4:0] regAddr;
  logic [15:0] wrData, rdData;
  logic breakExp, negTimeout, lossExp, blinkTick, blinkPhase_r;
  logic [2:0] nlpCount_r;
  logic tenLink_r, activity;
  logic [7:0] lfsr_r;
  pcl_neg_t negState_r, negState_nxt;
  pcl_led_mode_t mode;

  always_ff @(posedge clk_sys) begin
    strapS1_r <= strapPins;
    strapS2_r <= strapS1_r;
  end

  // Straps are taken a few cycles after release, once the synchroniser
  // holds pin levels rather than whatever it saw during reset.
  assign strapLoad = !strapDone_r && (settle_r == STRAP_SETTLE);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      settle_r <= '0;
      strapDone_r <= 1'b0;
    end else if (!strapDone_r) begin
      settle_r <= settle_r + 1'b1;
      strapDone_r <= strapLoad;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      strap_r <= STRAP_DEFAULT;
      strapIsolate_r <= 1'b0;
    end else if (strapLoad) begin
      strap_r <= strapS2_r;
      strapIsolate_r <= (strapS2_r.addr == 5'h00);
    end
  end

  pcl_mdio_slave u_mgmt (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .mdcPin(mdcPin),
    .mdioIn(mdioIn),
    .myAddr(stationAddr_r),
    .rdData(rdData),
    .mdioOut(mdioOut),
    .mdioOe_n(mdioOe_n),
    .wrStrobe(wrStrobe),
    .regAddr(regAddr),
    .wrData(wrData)
  );

  assign wrBasic = wrStrobe && (regAddr == REG_BASIC_CTRL);
  assign wrPhy = wrStrobe && (regAddr == REG_PHY_CTRL);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      anEn_r <= 1'b1;
      speed_r <= 1'b1;
      duplex_r <= 1'b1;
      isolate_r <= 1'b0;
      // Nothing negotiates before the straps have been taken.
      anArmed_r <= 1'b0;
    end else if (strapLoad) begin
      anEn_r <= strapS2_r.anEn;
      speed_r <= strapS2_r.an1;
      duplex_r <= strapS2_r.an0;
      anArmed_r <= strapS2_r.anEn;
    end else if (wrBasic) begin
      anEn_r <= wrData[BC_AN_EN];
      speed_r <= wrData[BC_SPEED];
      duplex_r <= wrData[BC_DUPLEX];
      isolate_r <= wrData[BC_ISOLATE];
      // A forced-strapped device only honours enable after a cleared write.
      anArmed_r <= anArmed_r || !wrData[BC_AN_EN];
    end
  end

  // A new restart write wins over the clear of an accepted one.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      restart_r <= 1'b0;
    end else if (wrBasic && wrData[BC_RESTART]) begin
      restart_r <= 1'b1;
    end else if (negState_r == NEG_BREAK || !negEnable) begin
      restart_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      xoverAuto_r <= 1'b1;
      xoverForce_r <= 1'b0;
      indicatorModeField_r <= 2'h1;
      stationAddr_r <= STATION_ADDR_DEFAULT;
    end else if (strapLoad) begin
      xoverAuto_r <= strapS2_r.xoverEn;
      indicatorModeField_r <= {1'b0, strapS2_r.ledCfg};
      stationAddr_r <= strapS2_r.addr;
    end else if (wrPhy) begin
      xoverAuto_r <= wrData[PC_XOVER_AUTO];
      xoverForce_r <= wrData[PC_XOVER_FORCE];
      indicatorModeField_r <= wrData[PC_LED_HI:PC_LED_LO];
      stationAddr_r <= wrData[PC_ADDR_LSB+:5];
    end
  end

  always_comb begin
    rdData = '0;
    if (regAddr == REG_BASIC_CTRL) begin
      rdData[BC_SPEED] = speed_r;
      rdData[BC_AN_EN] = anEn_r;
      rdData[BC_ISOLATE] = isolate_r;
      rdData[BC_RESTART] = restart_r;
      rdData[BC_DUPLEX] = duplex_r;
    end else if (regAddr == REG_PHY_CTRL) begin
      rdData[PC_XOVER_AUTO] = xoverAuto_r;
      rdData[PC_XOVER_FORCE] = xoverForce_r;
      rdData[PC_LED_HI:PC_LED_LO] = indicatorModeField_r;
      rdData[PC_ADDR_LSB+:5] = stationAddr_r;
    end
  end

  assign negEnable = anEn_r && anArmed_r;

  pcl_timer #(.LIMIT(BREAK_CYC)) u_break (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .restart(negState_r != NEG_BREAK),
    .expired(breakExp)
  );

  pcl_timer #(.LIMIT(NEG_CYC)) u_negLimit (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .restart(negState_r != NEG_RUN),
    .expired(negTimeout)
  );

  always_comb begin
    negState_nxt = negState_r;
    unique case (negState_r)
      NEG_OFF: if (negEnable) negState_nxt = NEG_BREAK;
      NEG_BREAK: if (breakExp) negState_nxt = NEG_RUN;
      NEG_RUN: begin
        if (restart_r || negTimeout) begin
          negState_nxt = NEG_BREAK;
        end else if (lineStat.negDone) begin
          negState_nxt = NEG_DONE;
        end
      end
      NEG_DONE: if (restart_r || !linkGood) negState_nxt = NEG_BREAK;
    endcase
    if (!negEnable) begin
      negState_nxt = NEG_OFF;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      negState_r <= NEG_OFF;
    end else begin
      negState_r <= negState_nxt;
    end
  end

  // Ten-megabit link needs an unbroken run of pulses; a gap longer than
  // the loss timer both drops the link and restarts the run.
  pcl_timer #(.LIMIT(LOSS_CYC)) u_loss (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .restart(lineStat.nlpPulse || lineStat.goodPacket),
    .expired(lossExp)
  );

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      nlpCount_r <= '0;
      tenLink_r <= 1'b0;
    end else if (lineStat.goodPacket) begin
      tenLink_r <= 1'b1;
    end else if (lineStat.nlpPulse) begin
      if (nlpCount_r == LINK_PULSES_LAST) begin
        tenLink_r <= 1'b1;
      end else begin
        nlpCount_r <= nlpCount_r + 1'b1;
      end
    end else if (lossExp) begin
      nlpCount_r <= '0;
      tenLink_r <= 1'b0;
    end
  end

  assign linkGood = lineStat.speed100 ? lineStat.sigDetect100 : tenLink_r;

  pcl_timer #(.LIMIT(BLINK_PERIOD)) u_blink (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .restart(blinkTick),
    .expired(blinkTick)
  );

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      lfsr_r <= SEED_DEFAULT;
    end else begin
      lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
    end
  end

  // Crossover retries on each blink tick with a random pair choice so two auto ends cannot lock step.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      xoverSel_r <= 1'b0;
    end else if (xoverForce_r) begin
      xoverSel_r <= 1'b1;
    end else if (!negEnable || !xoverAuto_r) begin
      xoverSel_r <= 1'b0;
    end else if (!linkGood && blinkTick) begin
      xoverSel_r <= lfsr_r[0];
    end
  end

  always_comb begin
    ctl.breakLink = (negState_r == NEG_BREAK);
    ctl.flpEnable = (negState_r == NEG_RUN);
    ctl.negComplete = (negState_r == NEG_DONE);
    ctl.forced = !negEnable;
    ctl.forcedSpeed100 = speed_r;
    ctl.forcedFull = duplex_r;
    ctl.xoverSwap = xoverSel_r;
    ctl.isolate = isolate_r || strapIsolate_r;
    ctl.txIgnore = ctl.isolate;
    ctl.idleOnly = ctl.isolate;
  end

  assign miiOe_n = ctl.isolate;

  assign activity = lineStat.txActive || lineStat.rxActive;
  assign mode = led_mode(indicatorModeField_r);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      blinkPhase_r <= 1'b0;
    end else if (blinkTick) begin
      blinkPhase_r <= !blinkPhase_r;
    end
  end

  // A strap pulled high turns its indicator into an active-low driver.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      linkIndicatorOut <= 1'b0;
      speedIndicatorOut <= 1'b0;
      activityCollisionIndicator <= 1'b0;
    end else begin
      speedIndicatorOut <= lineStat.speed100 ^ strap_r.an1;
      unique case (mode)
        LED_MODE1: begin
          linkIndicatorOut <= linkGood ^ strap_r.an0;
          activityCollisionIndicator <= activity ^ strap_r.anEn;
        end
        LED_MODE2: begin
          linkIndicatorOut <= (linkGood && !(activity && blinkPhase_r))
                              ^ strap_r.an0;
          activityCollisionIndicator <= (lineStat.collision
                                         && !lineStat.fullDuplex)
                                        ^ strap_r.anEn;
        end
        LED_MODE3: begin
          linkIndicatorOut <= (linkGood && !(activity && blinkPhase_r))
                              ^ strap_r.an0;
          activityCollisionIndicator <= lineStat.fullDuplex
                                        ^ strap_r.anEn;
        end
        default: begin
          linkIndicatorOut <= strap_r.an0;
          activityCollisionIndicator <= strap_r.anEn;
        end
      endcase
    end
  end

  a_restart_breaks:
    assert property (@(posedge clk_sys) disable iff (!reset_n)
      (negState_r == NEG_DONE && negEnable && restart_r)
      |=> negState_r == NEG_BREAK)
    else $error("Restart did not start the link break.");

  a_loss_renegotiate:
    assert property (@(posedge clk_sys) disable iff (!reset_n)
      (negState_r == NEG_DONE && negEnable && !linkGood)
      |=> ctl.breakLink && !ctl.flpEnable)
    else $error("Link loss did not resume negotiation.");

  a_break_holds:
    assert property (@(posedge clk_sys) disable iff (!reset_n)
      (negState_r == NEG_BREAK && negEnable && !breakExp)
      |=> negState_r == NEG_BREAK)
    else $error("Link break ended before its timer.");

  a_enable_armed:
    assert property (@(posedge clk_sys) disable iff (!reset_n)
      !anArmed_r |=> negState_r == NEG_OFF)
    else $error("Negotiation ran before enable was cleared.");

  a_neg_limit:
    assert property (@(posedge clk_sys) disable iff (!reset_n)
      (negState_r == NEG_RUN && negTimeout) |=> negState_r != NEG_RUN)
    else $error("Negotiation outlived its time limit.");

  a_force_swap:
    assert property (@(posedge clk_sys) disable iff (!reset_n)
      xoverForce_r |=> ctl.xoverSwap)
    else $error("Forced crossover did not swap pairs.");

  a_forced_no_auto:
    assert property (@(posedge clk_sys) disable iff (!reset_n)
      (!negEnable && !xoverForce_r) |=> !ctl.xoverSwap)
    else $error("Automatic crossover ran in forced mode.");

  a_written_addr_zero:
    assert property (@(posedge clk_sys) disable iff (!reset_n)
      (strapDone_r && wrPhy && !ctl.isolate) |=> !ctl.isolate)
    else $error("Address write changed strapped isolation.");

  a_speed_indicator:
    assert property (@(posedge clk_sys) disable iff (!reset_n)
      strapDone_r |=> speedIndicatorOut
        == ($past(lineStat.speed100) ^ strap_r.an1))
    else $error("Speed indicator does not follow the rate.");

  a_seven_pulses:
    assert property (@(posedge clk_sys) disable iff (!reset_n)
      (nlpCount_r == LINK_PULSES_LAST && lineStat.nlpPulse) |=> tenLink_r)
    else $error("Seventh link pulse did not raise the link.");

  a_restart_clears:
    assert property (@(posedge clk_sys) disable iff (!reset_n)
      (negState_r == NEG_BREAK && !wrBasic) |=> !restart_r)
    else $error("Restart bit did not clear itself.");

endmodule : pcl_phy_config
`default_nettype wire

// ### design/pcl_pkg.sv
// Constants, types and helpers for the transceiver configuration block.
// What this block does
// - Writing one to restart bit 9 restarts negotiation at any time.
// - Loss of valid link after negotiation resumes negotiation automatically.
// - Any restart silences data and link pulses for 1500 ms, then sends bursts.
// - After forced strapping, enable bit 12 must be cleared then set.
// - Negotiation should finish within about 2-3 seconds, else it restarts.
// - Automatic crossover defaults on, set by strap or bits 15:14, random seed.
// - Force-crossover bit 14 swaps pairs even with everything else disabled.
// - Automatic crossover does not run in forced speed and duplex mode.
// - Station address straps latch into control bits 4:0 at reset.
// - Strapped address zero isolates; written address zero does not.
// - Without straps the latched station address is 00001.
// - Writing one to isolate bit 10 enters isolate mode.
// - Isolate ignores transmit inputs, floats MII outputs, keeps management.
// - Isolate sends idles or link pulses only; negotiation continues.
// - Indicator mode from bits 6:5 or strap; bit5 mode1, 00 mode2, 10 mode3.
// - Mode 1 link indicator is on for good link, off otherwise.
// - Modes 2 and 3 link indicator is on for link and blinks on activity.
// - Activity indicator shows activity in mode 1, collision in mode 2.
// - Mode 3 activity indicator is on for full duplex, off for half.
// - Speed indicator is active at 100 Mb/s and inactive at 10 Mb/s.
// - 10 Mb/s link after seven link pulses or a packet; loss timer drops it.
// - Each indicator's active level follows its strap: low strap, active high.
// - The basic control register sits at management address 0x00.
package pcl_pkg;

  localparam logic [4:0] REG_BASIC_CTRL = 5'h00;
  localparam logic [4:0] REG_PHY_CTRL = 5'h19;

  localparam int BC_SPEED = 13;
  localparam int BC_AN_EN = 12;
  localparam int BC_ISOLATE = 10;
  localparam int BC_RESTART = 9;
  localparam int BC_DUPLEX = 8;
  localparam int PC_XOVER_AUTO = 15;
  localparam int PC_XOVER_FORCE = 14;
  localparam int PC_LED_HI = 6;
  localparam int PC_LED_LO = 5;
  localparam int PC_ADDR_LSB = 0;

  localparam logic [4:0] STATION_ADDR_DEFAULT = 5'h01;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  localparam logic [2:0] LINK_PULSES_LAST = 3'h6;
  localparam logic [7:0] SEED_DEFAULT = 8'hA5;

  localparam int unsigned CLK_KHZ = 100000;
  localparam int unsigned BREAK_LINK_MS = 1500;
  localparam int unsigned NEG_LIMIT_MS = 3000;
  localparam int unsigned LINK_LOSS_MS = 50;
  localparam int unsigned BLINK_MS = 50;
  localparam int unsigned BREAK_LINK_CYC = BREAK_LINK_MS * CLK_KHZ;
  localparam int unsigned NEG_LIMIT_CYC = NEG_LIMIT_MS * CLK_KHZ;
  localparam int unsigned LINK_LOSS_CYC = LINK_LOSS_MS * CLK_KHZ;
  localparam int unsigned BLINK_CYC = BLINK_MS * CLK_KHZ;

  localparam logic [5:0] PREAMBLE_ONES = 6'h20;
  localparam logic [3:0] HDR_LAST = 4'hB;
  localparam logic [3:0] DATA_LAST = 4'hF;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;

  typedef enum logic [1:0] {
    NEG_OFF = 2'b00,
    NEG_BREAK = 2'b01,
    NEG_RUN = 2'b10,
    NEG_DONE = 2'b11
  } pcl_neg_t;

  typedef enum logic [2:0] {
    MG_PRE = 3'b000,
    MG_START = 3'b001,
    MG_HDR = 3'b010,
    MG_TA = 3'b011,
    MG_DATA = 3'b100
  } pcl_mgmt_t;

  typedef enum logic [1:0] {
    LED_MODE1 = 2'b01,
    LED_MODE2 = 2'b10,
    LED_MODE3 = 2'b11
  } pcl_led_mode_t;

  typedef struct packed {
    logic [4:0] addr;
    logic anEn;
    logic an1;
    logic an0;
    logic xoverEn;
    logic ledCfg;
  } pcl_strap_t;

  localparam pcl_strap_t STRAP_DEFAULT = '{STATION_ADDR_DEFAULT, 1'h1,
                                           1'h1, 1'h1, 1'h1, 1'h1};

  typedef struct packed {
    logic sigDetect100;
    logic nlpPulse;
    logic goodPacket;
    logic speed100;
    logic fullDuplex;
    logic txActive;
    logic rxActive;
    logic collision;
    logic negDone;
  } pcl_line_t;

  typedef struct packed {
    logic breakLink;
    logic flpEnable;
    logic negComplete;
    logic forced;
    logic forcedSpeed100;
    logic forcedFull;
    logic xoverSwap;
    logic isolate;
    logic txIgnore;
    logic idleOnly;
  } pcl_ctl_t;

  function automatic pcl_led_mode_t led_mode(input logic [1:0] cfg);
    if (cfg[0]) begin
      return LED_MODE1;
    end
    return cfg[1] ? LED_MODE3 : LED_MODE2;
  endfunction : led_mode

endpackage : pcl_pkg

// ### design/pcl_timer.sv
// Restartable up-counter that flags when a fixed cycle count has elapsed.
`timescale 1ns/10ps
`default_nettype none
module pcl_timer #(
  parameter int unsigned LIMIT = 16
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic restart,
  output logic expired
);
  localparam int W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] LAST = W'(LIMIT);

  logic [W-1:0] count_r;

  // The count holds at its end so a late reader still sees the expiry.
  always_ff @(posedge clk_sys) begin
    if (!reset_n || restart) begin
      count_r <= '0;
    end else if (count_r != LAST) begin
      count_r <= count_r + 1'b1;
    end
  end

  assign expired = (count_r == LAST);

endmodule : pcl_timer
`default_nettype wire

// ### design/pcl_mdio_slave.sv
// Serial management frame receiver and read-data driver.
`timescale 1ns/10ps
`default_nettype none
module pcl_mdio_slave (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic mdcPin,
  input wire logic mdioIn,
  input wire logic [4:0] myAddr,
  input wire logic [15:0] rdData,
  output logic mdioOut,
  output logic mdioOe_n,
  output logic wrStrobe,
  output logic [4:0] regAddr,
  output logic [15:0] wrData
);
  import pcl_pkg::*;

  logic mdcS1_r, mdcS2_r, mdcS3_r, mdioS1_r, mdioS2_r;
  logic mdcRise, bitIn, reading_r;
  logic [5:0] ones_r;
  logic [3:0] cnt_r;
  logic [11:0] hdr_r;
  logic [11:0] hdrNow;
  logic [15:0] shift_r;
  pcl_mgmt_t state_r;

  always_ff @(posedge clk_sys) begin
    mdcS1_r <= mdcPin;
    mdcS2_r <= mdcS1_r;
    mdcS3_r <= mdcS2_r;
    mdioS1_r <= mdioIn;
    mdioS2_r <= mdioS1_r;
  end

  assign mdcRise = mdcS2_r && !mdcS3_r;
  assign bitIn = mdioS2_r;
  assign hdrNow = {hdr_r[10:0], bitIn};

  // Every transaction is decoded in isolate mode too.
  always_ff @(posedge clk_sys) begin
    wrStrobe <= 1'b0;
    if (!reset_n) begin
      state_r <= MG_PRE;
      ones_r <= '0;
      cnt_r <= '0;
      hdr_r <= '0;
      shift_r <= '0;
      reading_r <= 1'b0;
      mdioOut <= 1'b1;
      mdioOe_n <= 1'b1;
      regAddr <= '0;
      wrData <= '0;
    end else if (mdcRise) begin
      unique case (state_r)
        MG_PRE: begin
          if (bitIn) begin
            ones_r <= (ones_r == PREAMBLE_ONES) ? ones_r : ones_r + 1'b1;
          end else begin
            ones_r <= '0;
            if (ones_r == PREAMBLE_ONES) begin
              state_r <= MG_START;
            end
          end
        end
        MG_START: begin
          cnt_r <= '0;
          state_r <= bitIn ? MG_HDR : MG_PRE;
        end
        MG_HDR: begin
          hdr_r <= hdrNow;
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == HDR_LAST) begin
            cnt_r <= '0;
            regAddr <= hdrNow[4:0];
            // Another device on the shared bus owns other addresses.
            if (hdrNow[9:5] != myAddr) begin
              state_r <= MG_PRE;
            end else if (hdrNow[11:10] == OP_READ) begin
              reading_r <= 1'b1;
              state_r <= MG_TA;
            end else if (hdrNow[11:10] == OP_WRITE) begin
              reading_r <= 1'b0;
              state_r <= MG_TA;
            end else begin
              state_r <= MG_PRE;
            end
          end
        end
        MG_TA: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == 4'h0) begin
            mdioOut <= 1'b0;
            mdioOe_n <= !reading_r;
          end else begin
            cnt_r <= '0;
            mdioOut <= rdData[15];
            shift_r <= {rdData[14:0], 1'b0};
            state_r <= MG_DATA;
          end
        end
        MG_DATA: begin
          cnt_r <= cnt_r + 1'b1;
          if (reading_r) begin
            mdioOut <= shift_r[15];
            shift_r <= {shift_r[14:0], 1'b0};
          end else begin
            shift_r <= {shift_r[14:0], bitIn};
          end
          if (cnt_r == DATA_LAST) begin
            mdioOe_n <= 1'b1;
            mdioOut <= 1'b1;
            ones_r <= '0;
            state_r <= MG_PRE;
            wrStrobe <= !reading_r;
            wrData <= {shift_r[14:0], bitIn};
          end
        end
        default: begin
          state_r <= MG_PRE;
        end
      endcase
    end
  end

endmodule : pcl_mdio_slave
`default_nettype wire

// ### tb/pcl_mgmt_agent.sv
// Management agent model that clocks serial frames onto the shared line.
`timescale 1ns/10ps
`default_nettype none
module pcl_mgmt_agent (
  output var logic mdc,
  input wire logic mdioLine,
  output var logic mdioDrive
);
  initial begin
    mdc = 1'h0;
    mdioDrive = 1'h1;
  end
  // The clock only runs inside a frame; data changes while it is low.
  task automatic bitx(input logic b, output logic s);
    mdioDrive = b;
    #62.5;
    s = mdioLine;
    mdc = 1'h1;
    #62.5;
    mdc = 1'h0;
  endtask : bitx
  // A released line reads as the pull-up level, so release drives one.
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic s;
    logic [13:0] h;
    h = {2'h1, op, pa, ra};
    repeat (32) bitx(1'h1, s);
    for (int i = 13; i >= 0; i--) bitx(h[i], s);
    bitx(1'h1, s);
    bitx(op[1] ? 1'h1 : 1'h0, s);
    for (int i = 15; i >= 0; i--) bitx(wd[i], rd[i]);
    mdioDrive = 1'h1;
  endtask : xfer
endmodule : pcl_mgmt_agent
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the transceiver configuration block.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pcl_pkg::*;
  logic clk_sys = 1'h0;
  logic reset_n = 1'h0;
  logic mdc, mdioIn, mdioOut, mdioOe_n, agentOut, miiOe_n;
  logic linkLed, speedLed, actLed;
  logic [15:0] rd;
  pcl_strap_t strap = '{5'h01, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1};
  pcl_line_t ls = '0;
  pcl_ctl_t ctl;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  assign mdioIn = mdioOe_n ? agentOut : mdioOut;
  pcl_phy_config #(.BREAK_CYC(200), .NEG_CYC(1000), .LOSS_CYC(100),
    .BLINK_PERIOD(20)) i_pcl_phy_config (.clk_sys(clk_sys),
    .reset_n(reset_n), .mdcPin(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut),
    .mdioOe_n(mdioOe_n), .strapPins(strap), .lineStat(ls), .ctl(ctl),
    .miiOe_n(miiOe_n), .linkIndicatorOut(linkLed),
    .speedIndicatorOut(speedLed), .activityCollisionIndicator(actLed));
  pcl_mgmt_agent u_agent (.mdc(mdc), .mdioLine(mdioIn),
    .mdioDrive(agentOut));
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // Frames dominate the run time, so the ceiling allows about thirty-seven.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors = errors + 1;
      end_of_test();
    end
  end
  task automatic end_of_test;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [15:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic wr(input logic [4:0] pa, ra, input logic [15:0] d);
    u_agent.xfer(OP_WRITE, pa, ra, d, rd);
    cyc(6);
  endtask : wr
  task automatic rdc(input logic [4:0] pa, ra, input logic [15:0] e);
    u_agent.xfer(OP_READ, pa, ra, 16'hFFFF, rd);
    chk(rd, e);
  endtask : rdc
  task automatic pulse;
    ls.nlpPulse = 1'h1;
    cyc(1);
    ls.nlpPulse = 1'h0;
    cyc(4);
  endtask : pulse
  task automatic t_reset;
    chk(ctl.breakLink, 16'h0);
    rdc(5'h01, REG_PHY_CTRL, 16'h8021);
    rdc(5'h02, REG_PHY_CTRL, 16'hFFFF);
    rdc(5'h01, REG_BASIC_CTRL, 16'h2000);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_neg;
    wr(5'h01, REG_BASIC_CTRL, 16'h3000);
    chk(ctl.breakLink, 16'h0);
    wr(5'h01, REG_BASIC_CTRL, 16'h2000);
    wr(5'h01, REG_BASIC_CTRL, 16'h3000);
    chk({ctl.breakLink, ctl.flpEnable}, 16'h2);
    cyc(200);
    chk({ctl.breakLink, ctl.flpEnable}, 16'h1);
    ls.negDone = 1'h1;
    ls.speed100 = 1'h1;
    ls.sigDetect100 = 1'h1;
    cyc(3);
    chk(ctl.negComplete, 16'h1);
    ls.sigDetect100 = 1'h0;
    cyc(2);
    chk({ctl.breakLink, ctl.flpEnable}, 16'h2);
    ls.sigDetect100 = 1'h1;
    cyc(205);
    chk(ctl.negComplete, 16'h1);
    wr(5'h01, REG_BASIC_CTRL, 16'h3200);
    chk(ctl.breakLink, 16'h1);
    rdc(5'h01, REG_BASIC_CTRL, 16'h3000);
    ls.speed100 = 1'h0;
    ls.sigDetect100 = 1'h0;
    $display("t_neg done");
  endtask : t_neg
  task automatic t_iso;
    wr(5'h01, REG_BASIC_CTRL, 16'h0400);
    chk({ctl.isolate, ctl.txIgnore, ctl.idleOnly, miiOe_n}, 16'hF);
    rdc(5'h01, REG_BASIC_CTRL, 16'h0400);
    wr(5'h01, REG_BASIC_CTRL, 16'h0000);
    wr(5'h01, REG_PHY_CTRL, 16'h8020);
    chk({ctl.isolate, miiOe_n}, 16'h0);
    wr(5'h00, REG_PHY_CTRL, 16'h4021);
    chk(ctl.xoverSwap, 16'h1);
    wr(5'h01, REG_PHY_CTRL, 16'h8021);
    cyc(300);
    chk(ctl.xoverSwap, 16'h0);
    $display("t_iso done");
  endtask : t_iso
  task automatic t_led;
    logic [15:0] lows = 16'h0;
    repeat (6) pulse();
    chk(linkLed, 16'h0);
    pulse();
    chk(linkLed, 16'h1);
    ls.txActive = 1'h1;
    cyc(2);
    chk(actLed, 16'h1);
    ls.txActive = 1'h0;
    cyc(101);
    chk(linkLed, 16'h0);
    ls.speed100 = 1'h1;
    cyc(2);
    chk(speedLed, 16'h0);
    ls.fullDuplex = 1'h1;
    wr(5'h01, REG_PHY_CTRL, 16'h8041);
    chk(actLed, 16'h1);
    ls.fullDuplex = 1'h0;
    cyc(2);
    chk(actLed, 16'h0);
    ls.collision = 1'h1;
    wr(5'h01, REG_PHY_CTRL, 16'h8001);
    chk(actLed, 16'h1);
    ls.sigDetect100 = 1'h1;
    ls.txActive = 1'h1;
    cyc(2);
    // Any 42 cycles of blinking hold exactly one dark half-period.
    repeat (42) begin
      cyc(1);
      lows = lows + {15'h0, !linkLed};
    end
    chk(lows, 16'h15);
    ls.txActive = 1'h0;
    cyc(2);
    chk(linkLed, 16'h1);
    $display("t_led done");
  endtask : t_led
  task automatic t_strap;
    reset_n = 1'h0;
    strap = '{5'h00, 1'h1, 1'h0, 1'h1, 1'h0, 1'h0};
    cyc(4);
    reset_n = 1'h1;
    cyc(8);
    chk({ctl.isolate, miiOe_n}, 16'h3);
    chk({ctl.breakLink, ctl.forced, ctl.forcedFull}, 16'h5);
    chk({linkLed, speedLed, actLed}, 16'h2);
    rdc(5'h00, REG_PHY_CTRL, 16'h0000);
    rdc(5'h00, REG_BASIC_CTRL, 16'h1100);
    $display("t_strap done");
  endtask : t_strap
  initial begin
    cyc(16);
    reset_n = 1'h1;
    cyc(8);
    t_reset();
    t_neg();
    t_iso();
    t_led();
    t_strap();
    end_of_test();
  end
endmodule : tb
`default_nettype wire
